// ==== pcc_chk_sva.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Port-level checks of the counter and its register port
// ----------------------------------------------------------------------
module pcc_chk
  import pcc_pkg::*;
#(
  parameter bit CLEAR_ASYNC = 1'b1
) (
  input wire logic             REF_CLK_IN,
  input wire logic             RSTN_IN,
  input wire logic             CLEAR_N_IN,
  input wire logic             LOAD_N_IN,
  input wire logic             HOLD_GATE_ENABLE_IN,
  input wire logic             CHAIN_ENABLE_IN,
  input wire logic [CNT_W-1:0] PRESET_VALUE_IN,
  input wire logic             WB_CYC_IN,
  input wire logic             WB_STB_IN,
  input wire logic             WB_WE_IN,
  input wire logic [WB_AW-1:0] WB_ADR_IN,
  input wire logic [3:0]       WB_SEL_IN,
  input wire logic [WB_DW-1:0] WB_DAT_IN,
  input wire logic [WB_DW-1:0] WB_DAT_OUT,
  input wire logic             WB_ACK_OUT,
  input wire logic [CNT_W-1:0] COUNT_VALUE_OUT,
  input wire logic             WRAP_FLAG_OUT
);
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  // Pin-level checks assume the control register holds its reset value.
  chk_ack_taken: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT)
    else $error("ack missing one cycle after a request");
  chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_STB_IN))
    else $error("ack without a request");
  chk_dat_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == DAT_ZERO)
    else $error("read data not zero outside ack");
  chk_wrap_gate: assert property (WRAP_FLAG_OUT |-> CHAIN_ENABLE_IN && COUNT_VALUE_OUT == 4'hF)
    else $error("wrap flag without chain enable at all ones");
  chk_wrap_once: assert property ((WRAP_FLAG_OUT && CLEAR_N_IN && LOAD_N_IN && HOLD_GATE_ENABLE_IN)
    |=> !WRAP_FLAG_OUT)
    else $error("wrap flag longer than one period");
  chk_clear_zero: assert property (!CLEAR_N_IN |=> COUNT_VALUE_OUT == CNT_ZERO)
    else $error("count not zero after clear");
  chk_load_copy: assert property ((CLEAR_N_IN && !LOAD_N_IN) ##1 CLEAR_N_IN
    |-> COUNT_VALUE_OUT == $past(PRESET_VALUE_IN))
    else $error("load did not copy the preset");
  chk_count_step: assert property ((CLEAR_N_IN && LOAD_N_IN && HOLD_GATE_ENABLE_IN
    && CHAIN_ENABLE_IN) ##1 CLEAR_N_IN |-> COUNT_VALUE_OUT == $past(COUNT_VALUE_OUT) + 4'h1)
    else $error("count did not step by one");
  chk_count_hold: assert property ((CLEAR_N_IN && LOAD_N_IN
    && !(HOLD_GATE_ENABLE_IN && CHAIN_ENABLE_IN)) ##1 CLEAR_N_IN |-> $stable(COUNT_VALUE_OUT))
    else $error("count moved while inhibited");

  cover property ($rose(WRAP_FLAG_OUT));
  cover property (CLEAR_N_IN && !LOAD_N_IN);
  cover property (WB_ACK_OUT && WB_WE_IN);
endmodule: pcc_chk

bind pcc_top pcc_chk #(.CLEAR_ASYNC(CLEAR_ASYNC)) u_chk (
  .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .CLEAR_N_IN(CLEAR_N_IN),
  .LOAD_N_IN(LOAD_N_IN), .HOLD_GATE_ENABLE_IN(HOLD_GATE_ENABLE_IN),
  .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN), .PRESET_VALUE_IN(PRESET_VALUE_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .COUNT_VALUE_OUT(COUNT_VALUE_OUT), .WRAP_FLAG_OUT(WRAP_FLAG_OUT));

// ==== pcc_cnt_if.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Control and state bundle between the register side and the counter
// ----------------------------------------------------------------------
interface pcc_cnt_if;
  import pcc_pkg::*;

  logic             clear_n;
  logic             load_n;
  logic             hold_en;
  logic             chain_en;
  logic [CNT_W-1:0] preset;
  logic [CNT_W-1:0] count;
  logic             wrap;
  logic             known;
  logic             wrap_evt;

  modport ctl  (output clear_n, load_n, hold_en, chain_en, preset,
                input  count, wrap, known, wrap_evt);
  modport core (input  clear_n, load_n, hold_en, chain_en, preset,
                output count, wrap, known, wrap_evt);
  modport mon  (input  wrap_evt);

endinterface: pcc_cnt_if

// ==== pcc_core.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Four-bit presettable counter core
// ----------------------------------------------------------------------
module pcc_core
  import pcc_pkg::*;
#(
  parameter bit CLEAR_ASYNC = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  pcc_cnt_if.core   cnt
);

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             known_r;
  logic             known_nxt;
  logic             step;
  logic             arst_n;

  // In the asynchronous variant the clear joins the flop reset, so it acts
  // between edges; the synchronous variant only sees it at the next edge.
  assign arst_n = CLEAR_ASYNC ? (rst_n_in & cnt.clear_n) : rst_n_in;

  assign step = cnt.load_n & cnt.hold_en & cnt.chain_en;

  always_comb begin
    count_nxt = count_r;
    if (!cnt.clear_n) begin
      count_nxt = CNT_ZERO;
    end else if (!cnt.load_n) begin
      count_nxt = cnt.preset;
    end else if (step) begin
      count_nxt = CNT_W'(count_r + CNT_STEP);
    end
  end

  // The value is only trusted once a clear or a load has been seen.
  assign known_nxt = known_r | ~cnt.clear_n | ~cnt.load_n;

  always_ff @(posedge clk_in or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      known_r <= 1'b0;
    end else begin
      known_r <= known_nxt;
    end
  end

  assign cnt.count    = count_r;
  assign cnt.known    = known_r;
  assign cnt.wrap     = cnt.chain_en & (count_r == CNT_ALL_ONES);
  assign cnt.wrap_evt = cnt.clear_n & step & (count_r == CNT_ALL_ONES);

endmodule: pcc_core

// ==== pcc_pkg.sv ====
// ----------------------------------------------------------------------
// Shared constants of the presettable cascadable counter
// ----------------------------------------------------------------------
package pcc_pkg;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  localparam int unsigned CNT_W        = 4;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CNT_ALL_ONES = 4'hF;
  localparam logic [3:0]  CNT_STEP     = 4'h1;
  localparam int unsigned TALLY_W      = 16;
  localparam logic [15:0] TALLY_ZERO   = 16'h0000;
  localparam logic [15:0] TALLY_ONE    = 16'h0001;

  // --------------------------------------------------------------------
  // Wishbone geometry and register indexes (byte address = index * 4)
  // --------------------------------------------------------------------
  localparam int unsigned WB_AW      = 8;
  localparam int unsigned WB_DW      = 32;
  localparam int unsigned IDX_W      = 6;
  localparam logic [5:0]  IDX_CTRL   = 6'h00;
  localparam logic [5:0]  IDX_PRESET = 6'h01;
  localparam logic [5:0]  IDX_STATUS = 6'h02;
  localparam logic [5:0]  IDX_TALLY  = 6'h03;
  localparam logic [5:0]  IDX_CMD    = 6'h04;
  localparam logic [5:0]  IDX_PINS   = 6'h05;
  localparam logic [31:0] DAT_ZERO   = 32'h0000_0000;

  // --------------------------------------------------------------------
  // Field layouts and reset values
  // --------------------------------------------------------------------
  localparam int unsigned CTRL_W             = 5;
  localparam int unsigned CTRL_CLEAR_N_BIT   = 0;
  localparam int unsigned CTRL_LOAD_N_BIT    = 1;
  localparam int unsigned CTRL_HOLD_EN_BIT   = 2;
  localparam int unsigned CTRL_CHAIN_EN_BIT  = 3;
  localparam int unsigned CTRL_PRESET_SEL_BIT = 4;
  localparam logic [4:0]  CTRL_RESET         = 5'h0F;
  localparam int unsigned ST_COUNT_LSB       = 0;
  localparam int unsigned ST_WRAP_BIT        = 4;
  localparam int unsigned ST_KNOWN_BIT       = 5;
  localparam int unsigned ST_ASYNC_BIT       = 6;
  localparam int unsigned ST_MODE_LSB        = 8;
  localparam int unsigned CMD_CLR_TALLY_BIT  = 0;
  localparam int unsigned PINS_W             = 8;
  localparam logic [7:0]  PINS_RESET         = 8'h00;

  typedef enum logic [1:0] {
    PCC_MODE_CLEAR,
    PCC_MODE_LOAD,
    PCC_MODE_COUNT,
    PCC_MODE_INHIBIT
  } pcc_mode_t;

endpackage: pcc_pkg

// ==== pcc_top.sv ====
`timescale 1ns/1ns
// Function
// - Holds a 4-bit count that steps up in binary once per qualifying edge.
// - Counting and loading happen only on the rising clock edge.
// - Low load_n at an edge copies preset_value in and suppresses counting.
// - Low clear_n zeroes the count, overriding load and both enables.
// - Clear acts at once in the asynchronous build, at the edge otherwise.
// - Counts only with load_n high and both enables high; otherwise holds.
// - wrap_flag is chain_enable AND count all ones, combinational.
// - When counting through all ones wrap_flag stays high one clock period.
// ----------------------------------------------------------------------
// Top: counter with pins and a Wishbone register port
// ----------------------------------------------------------------------
module pcc_top
  import pcc_pkg::*;
#(
  parameter bit CLEAR_ASYNC = 1'b1
) (
  input  wire logic             REF_CLK_IN,
  input  wire logic             RSTN_IN,
  input  wire logic             CLEAR_N_IN,
  input  wire logic             LOAD_N_IN,
  input  wire logic             HOLD_GATE_ENABLE_IN,
  input  wire logic             CHAIN_ENABLE_IN,
  input  wire logic [CNT_W-1:0] PRESET_VALUE_IN,
  input  wire logic             WB_CYC_IN,
  input  wire logic             WB_STB_IN,
  input  wire logic             WB_WE_IN,
  input  wire logic [WB_AW-1:0] WB_ADR_IN,
  input  wire logic [3:0]       WB_SEL_IN,
  input  wire logic [WB_DW-1:0] WB_DAT_IN,
  output logic      [WB_DW-1:0] WB_DAT_OUT,
  output logic                  WB_ACK_OUT,
  output logic      [CNT_W-1:0] COUNT_VALUE_OUT,
  output logic                  WRAP_FLAG_OUT
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_r;
  logic [CTRL_W-1:0]  ctrl_nxt;
  logic [CNT_W-1:0]   preset_r;
  logic [CNT_W-1:0]   preset_nxt;
  logic               ack_r;
  logic               ack_nxt;
  logic [WB_DW-1:0]   rdat_r;
  logic [WB_DW-1:0]   rdat_nxt;
  pcc_mode_t          mode_r;
  pcc_mode_t          mode_nxt;
  logic [PINS_W-1:0]  pins_r;
  logic [PINS_W-1:0]  pins_nxt;
  logic [TALLY_W-1:0] tally;
  logic [WB_DW-1:0]   status_word;
  logic [WB_DW-1:0]   pins_word;
  logic [IDX_W-1:0]   idx;
  logic               req;
  logic               answer;
  logic               wr_take;
  logic               tally_clr;

  pcc_cnt_if cif ();

  // --------------------------------------------------------------------
  // Wishbone request decode
  // --------------------------------------------------------------------
  // Only byte lane 0 carries writable fields; the other lanes are ignored on write.
  assign idx     = WB_ADR_IN[WB_AW-1:2];
  assign req     = WB_CYC_IN & WB_STB_IN;
  assign answer  = req & ~ack_r;
  assign wr_take = req & WB_WE_IN & ack_r & WB_SEL_IN[0];

  // Writes land on the edge at which the master sees ack, never earlier,
  // so a request abandoned before ack leaves every register untouched.
  assign tally_clr = wr_take & (idx == IDX_CMD) & WB_DAT_IN[CMD_CLR_TALLY_BIT];

  // --------------------------------------------------------------------
  // Acknowledge
  // --------------------------------------------------------------------
  // One wait state: ack rises the edge after the request and falls one
  // edge later even if the master keeps the strobe up.
  always_comb begin
    ack_nxt = answer;
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Control and preset registers
  // --------------------------------------------------------------------
  always_comb begin
    ctrl_nxt   = ctrl_r;
    preset_nxt = preset_r;
    if (wr_take && (idx == IDX_CTRL)) begin
      ctrl_nxt = WB_DAT_IN[CTRL_W-1:0];
    end
    if (wr_take && (idx == IDX_PRESET)) begin
      preset_nxt = WB_DAT_IN[CNT_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_r   <= CTRL_RESET;
      preset_r <= CNT_ZERO;
    end else begin
      ctrl_r   <= ctrl_nxt;
      preset_r <= preset_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Merge pins with software controls
  // --------------------------------------------------------------------
  // Pin and register bit are ANDed, so either side can assert a low-true
  // clear or load and either side can inhibit counting. The clear term is
  // a flop output ANDed with a pin, so it adds no glitch of its own to the
  // asynchronous clear path.
  assign cif.clear_n  = CLEAR_N_IN & ctrl_r[CTRL_CLEAR_N_BIT];
  assign cif.load_n   = LOAD_N_IN & ctrl_r[CTRL_LOAD_N_BIT];
  assign cif.hold_en  = HOLD_GATE_ENABLE_IN & ctrl_r[CTRL_HOLD_EN_BIT];
  assign cif.chain_en = CHAIN_ENABLE_IN & ctrl_r[CTRL_CHAIN_EN_BIT];
  assign cif.preset   = ctrl_r[CTRL_PRESET_SEL_BIT] ? preset_r : PRESET_VALUE_IN;

  // --------------------------------------------------------------------
  // Operating mode of the last edge
  // --------------------------------------------------------------------
  always_comb begin
    if (!cif.clear_n) begin
      mode_nxt = PCC_MODE_CLEAR;
    end else if (!cif.load_n) begin
      mode_nxt = PCC_MODE_LOAD;
    end else if (cif.hold_en && cif.chain_en) begin
      mode_nxt = PCC_MODE_COUNT;
    end else begin
      mode_nxt = PCC_MODE_INHIBIT;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mode_r <= PCC_MODE_INHIBIT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Pin snapshot
  // --------------------------------------------------------------------
  // Sampled once per edge, so software sees the levels the counter used.
  always_comb begin
    pins_nxt = {PRESET_VALUE_IN, CHAIN_ENABLE_IN, HOLD_GATE_ENABLE_IN,
                LOAD_N_IN, CLEAR_N_IN};
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pins_r <= PINS_RESET;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  always_comb begin
    status_word = DAT_ZERO;
    status_word[ST_COUNT_LSB +: CNT_W] = cif.count;
    status_word[ST_WRAP_BIT]           = cif.wrap;
    status_word[ST_KNOWN_BIT]          = cif.known;
    status_word[ST_ASYNC_BIT]          = CLEAR_ASYNC;
    status_word[ST_MODE_LSB +: 2]      = mode_r;
  end

  always_comb begin
    pins_word = DAT_ZERO;
    pins_word[PINS_W-1:0] = pins_r;
  end

  // Data is loaded on the same edge that raises ack and is zero otherwise;
  // unmapped indexes answer with zero and writes to them are dropped.
  always_comb begin
    rdat_nxt = DAT_ZERO;
    if (answer) begin
      case (idx)
        IDX_CTRL: begin
          rdat_nxt[CTRL_W-1:0] = ctrl_r;
        end
        IDX_PRESET: begin
          rdat_nxt[CNT_W-1:0] = preset_r;
        end
        IDX_STATUS: begin
          rdat_nxt = status_word;
        end
        IDX_TALLY: begin
          rdat_nxt[TALLY_W-1:0] = tally;
        end
        IDX_PINS: begin
          rdat_nxt = pins_word;
        end
        default: begin
          rdat_nxt = DAT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdat_r <= DAT_ZERO;
    end else begin
      rdat_r <= rdat_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Counter core and wrap tally
  // --------------------------------------------------------------------
  pcc_core #(
    .CLEAR_ASYNC (CLEAR_ASYNC)
  ) u_core (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RSTN_IN),
    .cnt      (cif)
  );

  pcc_wrap_tally u_tally (
    .clk_in    (REF_CLK_IN),
    .rst_n_in  (RSTN_IN),
    .clr_in    (tally_clr),
    .mon       (cif),
    .tally_out (tally)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // The wrap flag must follow the chain enable without a clock, which is
  // what lets a cascade look ahead; it is the one output not from a flop.
  assign WB_ACK_OUT      = ack_r;
  assign WB_DAT_OUT      = rdat_r;
  assign COUNT_VALUE_OUT = cif.count;
  assign WRAP_FLAG_OUT   = cif.wrap;

endmodule: pcc_top

// ==== pcc_up_stage.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Upstream cascade stage feeding the chain enable
// ----------------------------------------------------------------------
module pcc_up_stage
  import pcc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  output logic      wrap_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = enable_in ? cnt_r + CNT_STEP : cnt_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // State moves only just after a rising edge, so the enable it feeds falls while clock is high.
  assign wrap_out = enable_in && (cnt_r == CNT_ALL_ONES);
endmodule: pcc_up_stage

// ==== pcc_wrap_tally.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Counts wraps of the counter for software
// ----------------------------------------------------------------------
module pcc_wrap_tally
  import pcc_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               clr_in,
  pcc_cnt_if.mon                  mon,
  output logic      [TALLY_W-1:0] tally_out
);

  logic [TALLY_W-1:0] tally_r;
  logic [TALLY_W-1:0] tally_nxt;

  // A wrap in the clearing cycle is kept, so a clear never loses an event.
  always_comb begin
    tally_nxt = tally_r;
    if (mon.wrap_evt) begin
      tally_nxt = clr_in ? TALLY_ONE : TALLY_W'(tally_r + TALLY_ONE);
    end else if (clr_in) begin
      tally_nxt = TALLY_ZERO;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tally_r <= TALLY_ZERO;
    end else begin
      tally_r <= tally_nxt;
    end
  end

  assign tally_out = tally_r;

endmodule: pcc_wrap_tally

// ==== tb_presettable_cascadable_counter4.sv ====
`timescale 1ns/1ns
module tb_presettable_cascadable_counter4;
  import pcc_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             clr_n = 1'b1;
  logic             ld_n = 1'b1;
  logic             hold = 1'b0;
  logic             chn_rnd = 1'b1;
  logic             use_up = 1'b0;
  logic             want_up = 1'b0;
  logic             up_en = 1'b0;
  logic             up_wrap;
  logic             chn;
  logic [CNT_W-1:0] pre = 4'h0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [WB_AW-1:0] adr = 8'h00;
  logic [3:0]       sel = 4'h0;
  logic [WB_DW-1:0] wdat = 32'h0000_0000;
  logic [WB_DW-1:0] dat_out;
  logic             ack;
  logic [CNT_W-1:0] cnt_out;
  logic             wrap_out;
  logic [CNT_W-1:0] cnt_sync;
  logic             wrap_sync;
  logic [CNT_W-1:0] exp_cnt = 4'h0;
  logic [CNT_W-1:0] exp_sync = 4'h0;
  logic [15:0]      exp_tally = 16'h0000;
  logic [31:0]      q;
  int               miscompares = 0;
  int               cmp_count = 0;

  assign chn = use_up ? up_wrap : chn_rnd;

  pcc_top #(.CLEAR_ASYNC(1'b1)) u_dut (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .CLEAR_N_IN(clr_n), .LOAD_N_IN(ld_n),
    .HOLD_GATE_ENABLE_IN(hold), .CHAIN_ENABLE_IN(chn), .PRESET_VALUE_IN(pre),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_out), .WB_ACK_OUT(ack), .COUNT_VALUE_OUT(cnt_out),
    .WRAP_FLAG_OUT(wrap_out));

  // The synchronous-clear build sees the same pins and bus and is checked alongside.
  pcc_top #(.CLEAR_ASYNC(1'b0)) u_dut_sync (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .CLEAR_N_IN(clr_n), .LOAD_N_IN(ld_n),
    .HOLD_GATE_ENABLE_IN(hold), .CHAIN_ENABLE_IN(chn), .PRESET_VALUE_IN(pre),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(), .WB_ACK_OUT(), .COUNT_VALUE_OUT(cnt_sync),
    .WRAP_FLAG_OUT(wrap_sync));

  pcc_up_stage u_up (.clk_in(clk), .rst_n_in(rstn), .enable_in(up_en), .wrap_out(up_wrap));

  initial begin
    forever #25 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask: finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask: check

  function automatic logic [3:0] nxt(input logic [3:0] cur);
    if (!clr_n) return CNT_ZERO;
    if (!ld_n) return pre;
    if (hold && chn) return cur + CNT_STEP;
    return cur;
  endfunction: nxt

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask: wb

  // Pins change just after the rising edge, so enables and load rise or fall with clock high.
  task automatic step(input logic c, input logic l, input logic h, input logic r,
                      input logic [3:0] p);
    @(posedge clk);
    if (clr_n && ld_n && hold && chn && exp_cnt == CNT_ALL_ONES) exp_tally++;
    exp_cnt = nxt(exp_cnt);
    exp_sync = nxt(exp_sync);
    clr_n <= c;
    ld_n <= l;
    hold <= h;
    chn_rnd <= r;
    pre <= p;
    up_en <= ($urandom % 4) != 0;
    use_up <= want_up;
    #5;
    // The asynchronous build clears at once; the synchronous one waits for the edge.
    if (!c) begin
      check(cnt_out, CNT_ZERO);
      check(cnt_sync, exp_sync);
      exp_cnt = CNT_ZERO;
    end
    @(negedge clk);
    check(cnt_out, exp_cnt);
    check(wrap_out, chn && exp_cnt == CNT_ALL_ONES);
    check(cnt_sync, exp_sync);
    check(wrap_sync, chn && exp_sync == CNT_ALL_ONES);
  endtask: step

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hE5E30319));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h08, DAT_ZERO, 4'hF);
    check(q, 32'h0000_0340);
    wb(1'b1, 8'h00, DAT_ZERO, 4'hE);
    wb(1'b0, 8'h00, DAT_ZERO, 4'hF);
    check(q, 32'h0000_000F);
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF, 4'hF);
    wb(1'b0, 8'h3C, DAT_ZERO, 4'hF);
    check(q, DAT_ZERO);
    step(1'b1, 1'b0, 1'b0, 1'b0, 4'hE);
    repeat (4) step(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
    step(1'b0, 1'b0, 1'b1, 1'b1, 4'h7);
    step(1'b1, 1'b1, 1'b0, 1'b1, 4'h3);
    step(1'b1, 1'b0, 1'b0, 1'b1, 4'h9);
    step(1'b1, 1'b1, 1'b0, 1'b1, 4'h9);
    wb(1'b1, 8'h00, 32'h0000_0007, 4'hF);
    wb(1'b0, 8'h00, DAT_ZERO, 4'hF);
    check(q, 32'h0000_0007);
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check(cnt_out, CNT_ZERO);
    check(cnt_sync, CNT_ZERO);
    @(posedge clk);
    rstn <= 1'b1;
    exp_cnt = CNT_ZERO;
    exp_sync = CNT_ZERO;
    exp_tally = TALLY_ZERO;
    wb(1'b0, 8'h00, DAT_ZERO, 4'hF);
    check(q, 32'h0000_000F);
    repeat (300) step(($urandom % 16) != 0, ($urandom % 8) != 0, ($urandom % 4) != 0,
                      ($urandom % 4) != 0, 4'($urandom));
    want_up = 1'b1;
    repeat (300) step(($urandom % 32) != 0, ($urandom % 16) != 0, ($urandom % 8) != 0,
                      1'b0, 4'($urandom));
    want_up = 1'b0;
    step(1'b1, 1'b1, 1'b0, 1'b1, 4'hA);
    wb(1'b0, 8'h0C, DAT_ZERO, 4'hF);
    check(q, {16'h0000, exp_tally});
    wb(1'b1, 8'h10, 32'h0000_0001, 4'hF);
    wb(1'b0, 8'h0C, DAT_ZERO, 4'hF);
    check(q, DAT_ZERO);
    wb(1'b0, 8'h14, DAT_ZERO, 4'hF);
    check(q, 32'h0000_00AB);
    wb(1'b0, 8'h08, DAT_ZERO, 4'hF);
    check(q, {22'h0, 2'h3, 1'b0, 2'h3, exp_cnt == CNT_ALL_ONES, exp_cnt});
    finish_test();
  end
endmodule: tb_presettable_cascadable_counter4
